// File: pkg/tso_regs.svh
`ifndef TSO_REGS_SVH
`define TSO_REGS_SVH

// ****************************************************************
// packet framing
// ****************************************************************
`define TSO_PKT_BYTES      8'hbc
`define TSO_BITS_PER_BYTE  4'h8
`define TSO_LAST_BIT       3'h7
`define TSO_IDX_MAX        8'hff

// ****************************************************************
// reset values
// ****************************************************************
`define TSO_RST_BYTE       8'h00
`define TSO_RST_BIT        1'b0
`define TSO_RST_READY      1'b1

`endif

// File: pkg/tso_pkg.sv
package tso_pkg;

   // ****************************************************************
   // configuration levels, all static while streaming
   // ****************************************************************
   typedef struct packed {
      logic clk_inv;
      logic first_inv;
      logic valid_inv;
      logic error_inv;
      logic rise_edge;
      logic serial_mode;
      logic redund_en;
   } tso_cfg_t;

   // ****************************************************************
   // one stream byte with its packet marks
   // ****************************************************************
   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       error;
   } tso_word_t;

   // ****************************************************************
   // stream pins
   // ****************************************************************
   typedef struct packed {
      logic       stream_out_clock;
      logic [7:0] parallel_stream_bus;
      logic       serial_stream_line;
      logic       first_byte_flag;
      logic       payload_valid_flag;
      logic       packet_error_flag;
   } tso_pins_t;

   typedef enum logic [1:0] {
      LK_IDLE,
      LK_BUSY
   } tso_link_state_t;

endpackage : tso_pkg

// File: hw/tso_xfer.sv
`timescale 1ns/1ps
`include "tso_regs.svh"

// ****************************************************************
// toggle handshake carrying one word from clk_src to clk_dst
// ****************************************************************
module tso_xfer (
   input  wire logic              clk_src,
   input  wire logic              clk_dst,
   input  wire logic              reset_n,
   input  wire logic              src_en,
   input  wire logic              dst_en,
   input  wire logic              src_valid,
   output      logic              src_ready,
   input  wire tso_pkg::tso_word_t src_word,
   output      logic              dst_valid,
   output      tso_pkg::tso_word_t dst_word,
   input  wire logic              dst_take
);
   import tso_pkg::*;

   logic      ready_r, ready_nxt;
   logic      req_r, req_nxt;
   tso_word_t word_r, word_nxt;
   logic      ack_s1_r, ack_s2_r;
   logic      req_s1_r, req_s2_r;
   logic      ack_r, ack_nxt;
   logic      dval_r, dval_nxt;
   tso_word_t dword_r, dword_nxt;

   assign src_ready = ready_r;
   assign dst_valid = dval_r;
   assign dst_word  = dword_r;

   // ****************************************************************
   // source side
   // ****************************************************************
   always_comb begin
      ready_nxt = ready_r;
      req_nxt   = req_r;
      word_nxt  = word_r;
      if (ready_r && src_valid) begin
         ready_nxt = 1'b0;
         req_nxt   = ~req_r;
         word_nxt  = src_word;
      end else if (!ready_r && (ack_s2_r == req_r)) begin
         ready_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_src or negedge reset_n) begin
      if (!reset_n) begin
         ready_r  <= `TSO_RST_READY;
         req_r    <= `TSO_RST_BIT;
         word_r   <= '0;
         ack_s1_r <= `TSO_RST_BIT;
         ack_s2_r <= `TSO_RST_BIT;
      end else if (src_en) begin
         ready_r  <= ready_nxt;
         req_r    <= req_nxt;
         word_r   <= word_nxt;
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // ****************************************************************
   // destination side
   // ****************************************************************
   // word_r is held unchanged until ack returns, so it is safe to sample
   always_comb begin
      ack_nxt   = ack_r;
      dval_nxt  = dval_r;
      dword_nxt = dword_r;
      if (dval_r && dst_take) begin
         dval_nxt = 1'b0;
         ack_nxt  = req_s2_r;
      end else if (!dval_r && (req_s2_r != ack_r)) begin
         dval_nxt  = 1'b1;
         dword_nxt = word_r;
      end
   end

   always_ff @(posedge clk_dst or negedge reset_n) begin
      if (!reset_n) begin
         req_s1_r <= `TSO_RST_BIT;
         req_s2_r <= `TSO_RST_BIT;
         ack_r    <= `TSO_RST_BIT;
         dval_r   <= `TSO_RST_BIT;
         dword_r  <= '0;
      end else if (dst_en) begin
         req_s1_r <= req_r;
         req_s2_r <= req_s1_r;
         ack_r    <= ack_nxt;
         dval_r   <= dval_nxt;
         dword_r  <= dword_nxt;
      end
   end

endmodule : tso_xfer

// File: hw/tso_top.sv
`timescale 1ns/1ps
`include "tso_regs.svh"

// Operation
// RULE1 - Separate configuration bits invert the output clock, first-byte, payload-valid and error flags.
// RULE2 - Stream outputs change on the falling output-clock edge unless the rising edge is selected.
// RULE3 - In serial mode the first-byte flag stands for exactly the eight bit periods of byte one.
// RULE4 - With redundancy enabled payload-valid is active only over the 188 data bytes.
// RULE5 - A packet marked uncorrectable keeps the error flag active over the whole packet; the code drops the error flag to inactive on each underrun.
// RULE6 - Serial mode drives one bit line, parallel mode one byte per output-clock cycle on eight lines.
// RULE7 - Without redundancy payload-valid stays asserted and packets are 188 bytes; the code drops payload-valid to inactive on each underrun.
// RULE8 - Serial bytes go out most significant bit first, for sampling on the opposite clock edge.
module tso_top (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire logic              link_clk,
   input  wire tso_pkg::tso_cfg_t cfg,
   input  wire logic              in_valid,
   output      logic              in_ready,
   input  wire logic [7:0]        in_data,
   input  wire logic              in_first,
   input  wire logic              in_error,
   output      tso_pkg::tso_pins_t pins
);
   import tso_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic pin_level(input logic raw, input logic inv);
      pin_level = raw ^ inv;
   endfunction : pin_level

   // output edges are the ones on which the pin moves to the launch level
   function automatic logic launch_edge(input logic phase, input tso_cfg_t c);
      launch_edge = (pin_level(phase, c.clk_inv) == c.rise_edge);
   endfunction : launch_edge

   // one place for flag polarity, so launch and underrun cannot disagree
   function automatic tso_pins_t set_flags(input tso_pins_t p,
                                           input tso_cfg_t  c,
                                           input logic      f,
                                           input logic      v,
                                           input logic      e);
      set_flags                    = p;
      set_flags.first_byte_flag    = pin_level(f, c.first_inv);
      set_flags.payload_valid_flag = pin_level(v, c.valid_inv);
      set_flags.packet_error_flag  = pin_level(e, c.error_inv);
   endfunction : set_flags

   // index saturates so a runaway packet never wraps back into payload
   function automatic logic [7:0] next_index(input logic [7:0] idx, input logic first);
      if (first) begin
         next_index = `TSO_RST_BYTE;
      end else if (idx != `TSO_IDX_MAX) begin
         next_index = idx + 8'h01;
      end else begin
         next_index = idx;
      end
   endfunction : next_index

   // ****************************************************************
   // declarations
   // ****************************************************************
   tso_word_t       sys_word;
   tso_word_t       lk_word;
   logic            lk_valid;
   logic            lk_take;

   logic            en_s1_r;
   logic            en_s1_nxt;
   logic            en_s2_r;
   logic            en_s2_nxt;
   tso_cfg_t        cfg_s1_r;
   tso_cfg_t        cfg_s1_nxt;
   tso_cfg_t        cfg_s2_r;
   tso_cfg_t        cfg_s2_nxt;
   logic            lk_en;

   logic            phase_r;
   logic            phase_nxt;
   logic            tick;
   logic            need_byte;
   logic            take_byte;
   logic            underrun;
   logic            mid_byte;

   tso_link_state_t st_r;
   tso_link_state_t st_nxt;
   logic [7:0]      shift_r;
   logic [7:0]      shift_nxt;
   logic [2:0]      bit_cnt_r;
   logic [2:0]      bit_cnt_nxt;
   logic [7:0]      idx_r;
   logic [7:0]      idx_nxt;
   logic            err_pkt_r;
   logic            err_pkt_nxt;
   logic            first_raw;
   logic            valid_raw;

   tso_pins_t       pins_r;
   tso_pins_t       pins_nxt;

   assign pins     = pins_r;
   assign sys_word = '{data: in_data, first: in_first, error: in_error};

   // ****************************************************************
   // crossing from system to link clock
   // ****************************************************************
   tso_xfer u_xfer (
      .clk_src   (clk_sys),
      .clk_dst   (link_clk),
      .reset_n   (reset_n),
      .src_en    (clk_en),
      .dst_en    (lk_en),
      .src_valid (in_valid),
      .src_ready (in_ready),
      .src_word  (sys_word),
      .dst_valid (lk_valid),
      .dst_word  (lk_word),
      .dst_take  (lk_take)
   );

   // ****************************************************************
   // enable and configuration synchronisers
   // ****************************************************************
   // not gated by lk_en: the enable itself has to travel while the link is held
   always_comb begin
      en_s1_nxt = clk_en;
      en_s2_nxt = en_s1_r;
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         en_s1_r <= `TSO_RST_BIT;
         en_s2_r <= `TSO_RST_BIT;
      end else begin
         en_s1_r <= en_s1_nxt;
         en_s2_r <= en_s2_nxt;
      end
   end

   assign lk_en = en_s2_r;

   // config bits are quasi-static; a change mid-packet may glitch one byte
   always_comb begin
      cfg_s1_nxt = cfg;
      cfg_s2_nxt = cfg_s1_r;
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_s1_r <= '0;
         cfg_s2_r <= '0;
      end else begin
         cfg_s1_r <= cfg_s1_nxt;
         cfg_s2_r <= cfg_s2_nxt;
      end
   end

   // ****************************************************************
   // output clock and launch edge
   // ****************************************************************
   // output clock is link_clk / 2; outputs launch with the chosen pin edge
   always_comb begin
      phase_nxt = ~phase_r;
      tick      = launch_edge(phase_nxt, cfg_s2_r); // RULE2
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_r <= `TSO_RST_BIT;
      end else if (lk_en) begin
         phase_r <= phase_nxt;
      end
   end

   // ****************************************************************
   // byte boundary decode
   // ****************************************************************
   // a boundary on every tick in parallel mode, on every eighth in serial
   always_comb begin
      need_byte = (st_r == LK_IDLE) || !cfg_s2_r.serial_mode || (bit_cnt_r == 3'h0);
      take_byte = tick && need_byte && lk_valid;
      underrun  = tick && need_byte && !lk_valid;
      mid_byte  = tick && !need_byte;
      lk_take   = take_byte;
   end

   // ****************************************************************
   // packet position and error mark
   // ****************************************************************
   // error is latched once per packet, so it covers redundancy bytes too
   always_comb begin
      idx_nxt     = idx_r;
      err_pkt_nxt = err_pkt_r;
      if (take_byte) begin
         idx_nxt = next_index(idx_r, lk_word.first);
         if (lk_word.first) begin
            err_pkt_nxt = lk_word.error; // RULE5
         end
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_r     <= `TSO_RST_BYTE;
         err_pkt_r <= `TSO_RST_BIT;
      end else if (lk_en) begin
         idx_r     <= idx_nxt;
         err_pkt_r <= err_pkt_nxt;
      end
   end

   // ****************************************************************
   // bit shifter
   // ****************************************************************
   // an underrun drops back to idle so the next byte opens a fresh boundary
   always_comb begin
      st_nxt      = st_r;
      shift_nxt   = shift_r;
      bit_cnt_nxt = bit_cnt_r;
      if (take_byte) begin
         st_nxt = LK_BUSY;
         if (cfg_s2_r.serial_mode) begin
            shift_nxt   = {lk_word.data[6:0], 1'b0}; // RULE8
            bit_cnt_nxt = `TSO_LAST_BIT;
         end else begin
            shift_nxt   = `TSO_RST_BYTE;
            bit_cnt_nxt = 3'h0;
         end
      end else if (underrun) begin
         st_nxt      = LK_IDLE;
         bit_cnt_nxt = 3'h0;
      end else if (mid_byte) begin
         shift_nxt   = {shift_r[6:0], 1'b0}; // RULE8
         bit_cnt_nxt = bit_cnt_r - 3'h1; // RULE3
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r      <= LK_IDLE;
         shift_r   <= `TSO_RST_BYTE;
         bit_cnt_r <= 3'h0;
      end else if (lk_en) begin
         st_r      <= st_nxt;
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_cnt_nxt;
      end
   end

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   // polarity is applied before the register, so every pin is a clean flop
   always_comb begin
      first_raw = 1'b0;
      valid_raw = 1'b0;
      pins_nxt  = pins_r;
      pins_nxt.stream_out_clock = pin_level(phase_nxt, cfg_s2_r.clk_inv); // RULE1
      if (take_byte) begin
         first_raw = lk_word.first; // RULE3
         // without redundancy every byte is payload
         valid_raw = !cfg_s2_r.redund_en || (idx_nxt < `TSO_PKT_BYTES); // RULE4 RULE7
         if (cfg_s2_r.serial_mode) begin
            pins_nxt.serial_stream_line = lk_word.data[7]; // RULE8
         end else begin
            pins_nxt.parallel_stream_bus = lk_word.data; // RULE6
         end
         pins_nxt = set_flags(pins_nxt, cfg_s2_r, first_raw, valid_raw, err_pkt_nxt); // RULE1
      end else if (underrun) begin
         // underrun: flags drop to inactive, data lines hold
         pins_nxt = set_flags(pins_nxt, cfg_s2_r, 1'b0, 1'b0, 1'b0);
      end else if (mid_byte) begin
         // mid-byte: flags hold so first-byte spans all eight bits
         pins_nxt.serial_stream_line = shift_r[7]; // RULE6 RULE8
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_r <= '0;
      end else if (lk_en) begin
         pins_r <= pins_nxt;
      end
   end

endmodule : tso_top

// File: bench/tso_top_sva.sv
`timescale 1ns/1ps
module tso_chk (
   input wire logic               link_clk,
   input wire logic               reset_n,
   input wire tso_pkg::tso_cfg_t  cfg,
   input wire tso_pkg::tso_pins_t pins
);
   import tso_pkg::*;
   logic       f_act;
   logic       v_act;
   logic       e_act;
   logic       tk;
   logic       live_r;
   logic       live_nxt;
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   assign f_act = pins.first_byte_flag ^ cfg.first_inv;
   assign v_act = pins.payload_valid_flag ^ cfg.valid_inv;
   assign e_act = pins.packet_error_flag ^ cfg.error_inv;
   assign tk    = pins.stream_out_clock == cfg.rise_edge;
   // runs started before an idle level was seen are ghosts of reset
   always_comb begin
      live_nxt = live_r | !f_act;
      run_nxt  = f_act ? run_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         live_r <= 1'b0;
         run_r  <= 8'h00;
      end else begin
         live_r <= live_nxt;
         run_r  <= run_nxt;
      end
   end
   default clocking @(posedge link_clk); endclocking
   default disable iff (!reset_n);
   property p_first_launch;
      $rose(f_act) |-> tk;
   endproperty
   a_first_launch: assert property (p_first_launch) else $error("first flag off launch");
   property p_bus_launch;
      $changed(pins.parallel_stream_bus) |-> tk;
   endproperty
   a_bus_launch: assert property (p_bus_launch) else $error("bus moved off launch");
   property p_first_len;
      live_r && $fell(f_act) |-> run_r == (cfg.serial_mode ? 8'h10 : 8'h02);
   endproperty
   a_first_len: assert property (p_first_len) else $error("first flag length");
   property p_valid_launch;
      $changed(v_act) |-> tk;
   endproperty
   a_valid_launch: assert property (p_valid_launch) else $error("valid off launch");
   property p_err_hold;
      $rose(f_act) |=> $stable(e_act);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error moved in byte one");
   property p_bus_hold;
      !cfg.serial_mode && $changed(pins.parallel_stream_bus) |=> $stable(pins.parallel_stream_bus);
   endproperty
   a_bus_hold: assert property (p_bus_hold) else $error("byte shorter than period");
   property p_valid_on;
      $changed(pins.parallel_stream_bus) && !cfg.serial_mode && !cfg.redund_en |-> v_act;
   endproperty
   a_valid_on: assert property (p_valid_on) else $error("valid low on byte");
   property p_line_launch;
      $changed(pins.serial_stream_line) |-> tk;
   endproperty
   a_line_launch: assert property (p_line_launch) else $error("bit moved off launch");
   c_ser: cover property (cfg.serial_mode && live_r && $fell(f_act));
   c_par: cover property (!cfg.serial_mode && $rose(f_act));
   c_red: cover property (cfg.redund_en && $fell(v_act));
endmodule : tso_chk

bind tso_top tso_chk u_chk (.link_clk(link_clk), .reset_n(reset_n), .cfg(cfg), .pins(pins));

// File: bench/tso_sink.sv
`timescale 1ns/1ps
module tso_sink (
   input wire logic               reset_n,
   input wire tso_pkg::tso_cfg_t  cfg,
   input wire tso_pkg::tso_pins_t pins
);
   import tso_pkg::*;
   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       valid;
      logic       error;
   } tso_rx_t;
   tso_rx_t    q[$];
   logic [7:0] sh = 8'h00;
   logic [7:0] last = 8'h00;
   logic       f;
   logic       v;
   logic       e;
   logic       fp = 1'b0;
   int         bits = 0;
   int         flen = 0;
   // sample on the pin edge opposite to launch
   always @(pins.stream_out_clock or negedge reset_n) begin
      // a reset forgets the old packet, so stale bytes cannot pass a later check
      if (!reset_n) begin
         q.delete();
         bits = 0;
         flen = 0;
         fp   = 1'b0;
         last = 8'h00;
      end else if (pins.stream_out_clock != cfg.rise_edge) begin
         f = pins.first_byte_flag ^ cfg.first_inv;
         v = pins.payload_valid_flag ^ cfg.valid_inv;
         e = pins.packet_error_flag ^ cfg.error_inv;
         bits = bits + 1;
         // a new packet start drops what was seen before
         if (f && !fp) begin
            q.delete();
            bits = 1;
            flen = 0;
         end
         if (f)
            flen = flen + 1;
         fp = f;
         if (cfg.serial_mode) begin
            sh = {sh[6:0], pins.serial_stream_line};
            if (bits == 8) begin
               q.push_back({sh, f, v, e});
               bits = 0;
            end
         end else if (pins.parallel_stream_bus != last) begin
            last = pins.parallel_stream_bus;
            q.push_back({last, f, v, e});
         end
      end
   end
endmodule : tso_sink

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import tso_pkg::*;
   typedef struct packed {
      tso_cfg_t   cfg;
      logic       err;
      logic [3:0] flen;
      logic [7:0] nval;
   } tso_row_t;
   localparam tso_row_t rows [5] = '{'{7'h02, 1'b1, 4'h8, 8'hbe}, '{7'h7f, 1'b0, 4'h8, 8'hbc},
      '{7'h00, 1'b1, 4'h1, 8'hbe}, '{7'h2d, 1'b1, 4'h1, 8'hbc}, '{7'h53, 1'b0, 4'h8, 8'hbc}};
   logic       clk_sys = 1'b0;
   logic       link_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       clk_en = 1'b1;
   logic       in_valid = 1'b0;
   logic       in_ready;
   logic [7:0] in_data = 8'h00;
   logic       in_first = 1'b0;
   logic       in_error = 1'b0;
   tso_cfg_t   cfg = '0;
   tso_pins_t  pins;
   tso_pins_t  pins_hold;
   int         bad_count = 0;
   int         checks_done = 0;
   always #10 clk_sys = ~clk_sys;
   always #6 link_clk = ~link_clk;
   tso_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .link_clk(link_clk),
      .cfg(cfg), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
      .in_first(in_first), .in_error(in_error), .pins(pins));
   tso_sink sink (.reset_n(reset_n), .cfg(cfg), .pins(pins));
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rst(input tso_cfg_t c);
      reset_n <= 1'b0;
      cfg     <= c;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask : rst
   // fields move only at the take edge, so valid stays up between bytes
   task automatic send(input int n, input logic err);
      int t;
      for (int i = 0; i < n; i++) begin
         in_valid <= 1'b1;
         in_data  <= 8'(i + 1);
         in_first <= (i == 0);
         in_error <= err;
         t = 0;
         do begin
            @(posedge clk_sys);
            t++;
         end while (in_ready !== 1'b1 && t < 200);
         chk("ready", 8'h01, {7'h00, in_ready === 1'b1});
      end
      in_valid <= 1'b0;
      repeat (60) @(posedge clk_sys);
   endtask : send
   task automatic stop_test;
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   initial begin
      repeat (40000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      chk("ready_rst", 8'h01, {7'h00, in_ready});
      chk("pins_rst", 8'h00, {7'h00, |pins});
      foreach (rows[r]) begin
         rst(rows[r].cfg);
         send(190, rows[r].err);
         chk("count", 8'h01, {7'h00, sink.q.size() >= 190});
         chk("flen", {4'h0, rows[r].flen}, 8'(sink.flen));
         for (int i = 0; i < 190 && i < sink.q.size(); i++) begin
            chk("data", 8'(i + 1), sink.q[i].data);
            chk("first", {7'h00, i == 0}, {7'h00, sink.q[i].first});
            chk("valid", {7'h00, i < rows[r].nval}, {7'h00, sink.q[i].valid});
            chk("error", {7'h00, rows[r].err}, {7'h00, sink.q[i].error});
         end
      end
      // error packet straight after a clean-up must not leak into the next
      rst(7'h00);
      send(5, 1'b1);
      send(5, 1'b0);
      chk("err_next", 8'h00, {7'h00, sink.q[0].error});
      chk("count_next", 8'h05, 8'(sink.q.size()));
      // clock enable low must freeze the link, output clock included
      clk_en <= 1'b0;
      repeat (5) @(posedge clk_sys);
      pins_hold = pins;
      repeat (20) @(posedge clk_sys);
      chk("freeze", 8'h00, {7'h00, pins !== pins_hold});
      clk_en <= 1'b1;
      repeat (5) @(posedge clk_sys);
      stop_test();
   end
endmodule : tb_top
